// ---- hw/cpc_pkg.sv ----
// Register map, field positions and encodings of the compare/PWM pair
package cpc_pkg;
  localparam int CNT_W = 16;
  localparam int NCH = 2;
  localparam int ADDR_W = 8;
  localparam int PS_W = 3;
  localparam int DIV_W = 6;
  localparam int CFG_W = 9;
  // Byte offsets on the register bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MOD = 8'h04;
  localparam logic [7:0] OFF_CNT = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_CFG0 = 8'h10;
  localparam logic [7:0] OFF_VAL0 = 8'h14;
  localparam logic [7:0] CH_STRIDE = 8'h08;
  // Control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PS_LSB = 1;
  localparam int CTRL_CRST = 4;
  // Status register fields
  localparam int ST_OVF = 0;
  localparam int ST_OVFIE = 1;
  // Channel configuration fields
  localparam int CF_FLAG = 0;
  localparam int CF_IE = 1;
  localparam int CF_DMA = 2;
  localparam int CF_PWM = 3;
  localparam int CF_BUF = 4;
  localparam int CF_ACT_LSB = 5;
  localparam int CF_TOV = 7;
  localparam int CF_MAX = 8;
  localparam int CF_ACTB = 9;
  // Match actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOG = 2'h1;
  localparam logic [1:0] ACT_CLR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // Reset values
  localparam logic [CNT_W-1:0] MOD_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0] VAL_RST = 16'h0000;
  localparam logic [CFG_W-1:0] CFG_RST = 9'h000;
  localparam logic [PS_W-1:0] PS_RST = 3'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- hw/cpc_top.sv ----
// Output compare and PWM channel pair on a 16-bit modulo counter
//
// How it works
// - Counter equal to channel value sets flag
// - Enabled flag raises CPU or DMA request
// - Match sets, clears or toggles the pin
// - Toggle-on-overflow inverts compare-mode pin at each wrap
// - New value written is used next match
// - Unbuffered write takes effect immediately
// - Match ends pulse, overflow ends period
// - Two channels join as one buffered channel
// - Written inactive register becomes active at overflow
// - Pair works on first channel; second freed
// - PWM pulse starts at modulo overflow
// - PWM channel match ends the pulse
// - Period is modulo value plus one
// - Duty equals channel value over period
// - Selectable polarity, forced full duty, zero duty at value 0
// - Resolution is one counter clock tick
// - PWM flag at pulse end, overflow period end
// - Buffered PWM match on active register flags
// - Modulo value held as high and low byte
`timescale 1ns/1ps
module cpc_top
  import cpc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NCH-1:0] output_compare,
  output logic [NCH-1:0] output_compare_oe,
  output logic cpu_irq,
  output logic [NCH-1:0] dma_req
);

  // Bus capture
  logic [ADDR_W-1:0] aw_q, aw_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  // Timer state
  logic run_q;
  logic [PS_W-1:0] ps_q;
  logic [DIV_W-1:0] div_q;
  logic [CNT_W-1:0] mod_q;
  logic [CNT_W-1:0] cnt_q;
  logic ovf_flag_q, ovf_ie_q;
  logic act_b_q, pend_q;
  logic [CFG_W-1:0] cfg_q [NCH];
  logic [CNT_W-1:0] val_q [NCH];
  logic [NCH-1:0] flag_q;
  logic [NCH-1:0] dma_req_sel, ie_sel;

  // Write decode
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire [31:0] wmask = {{8{ws_q[3]}}, {8{ws_q[2]}},
                       {8{ws_q[1]}}, {8{ws_q[0]}}};
  wire [31:0] wbits = wd_q & wmask;
  wire wr_ctrl = wr_go && (aw_q == OFF_CTRL);
  wire wr_mod = wr_go && (aw_q == OFF_MOD);
  wire wr_stat = wr_go && (aw_q == OFF_STAT);
  wire [NCH-1:0] wr_cfg;
  wire [NCH-1:0] wr_val;
  wire [NCH-1:0] map_w;
  wire [NCH-1:0] map_r;
  wire wr_hit = wr_ctrl || wr_mod || wr_stat || (aw_q == OFF_CNT) ||
                (|map_w);

  // Prescaler: one-cycle counter tick
  wire [6:0] ps_mask7 = (7'h01 << ps_q) - 7'h01;
  wire [DIV_W-1:0] ps_mask = ps_mask7[DIV_W-1:0];
  wire tick = run_q && ((div_q & ps_mask) == ps_mask);
  wire crst = wr_ctrl && wbits[CTRL_CRST];
  wire wrap = (cnt_q == mod_q) || (cnt_q == {CNT_W{1'b1}});
  wire ovf = tick && wrap;
  wire [CNT_W-1:0] cnt_nx = wrap ? '0 : cnt_q + 16'h0001;
  wire buf_on = cfg_q[0][CF_BUF];

  // Read path
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL: rd_mux = {28'h000_0000, ps_q, run_q};
      OFF_MOD: rd_mux = {16'h0000, mod_q};
      OFF_CNT: rd_mux = {16'h0000, cnt_q};
      OFF_STAT: rd_mux = {30'h0000_0000, ovf_ie_q, ovf_flag_q};
      default: begin
        rd_hit = |map_r;
        for (int i = 0; i < NCH; i++) begin
          if (s_axi_araddr == OFF_CFG0 + CH_STRIDE * i[7:0]) begin
            rd_mux = {22'h00_0000, (i == 0) & act_b_q,
                      cfg_q[i][CFG_W-1:1], flag_q[i]};
          end
          if (s_axi_araddr == OFF_VAL0 + CH_STRIDE * i[7:0]) begin
            rd_mux = {16'h0000, val_q[i]};
          end
        end
      end
    endcase
  end

  always_comb begin
    aw_d = aw_q;
    wd_d = wd_q;
    ws_d = ws_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
  end

  // Register bus slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_q <= '0;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end else begin
      aw_q <= aw_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Prescaler and modulo counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
      ps_q <= PS_RST;
      div_q <= '0;
      cnt_q <= '0;
      mod_q <= MOD_RST;
    end else begin
      if (wr_ctrl && ws_q[0]) begin
        run_q <= wd_q[CTRL_RUN];
        ps_q <= wd_q[CTRL_PS_LSB +: PS_W];
      end
      if (wr_mod) begin
        mod_q <= (mod_q & ~wmask[CNT_W-1:0]) | wbits[CNT_W-1:0];
      end
      if (crst) begin
        div_q <= '0;
        cnt_q <= '0;
      end else if (run_q) begin
        div_q <= div_q + 6'h01;
        if (tick) begin
          cnt_q <= cnt_nx;
        end
      end
    end
  end

  // Overflow flag and buffered-pair register selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_flag_q <= 1'b0;
      ovf_ie_q <= 1'b0;
      act_b_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      // Overflow marks the end of the period; set beats clear
      ovf_flag_q <= ovf ||
                    (ovf_flag_q && !(wr_stat && wbits[ST_OVF]));
      if (wr_stat && ws_q[0]) begin
        ovf_ie_q <= wd_q[ST_OVFIE];
      end
      if (!buf_on) begin
        act_b_q <= 1'b0;
        pend_q <= 1'b0;
      end else begin
        if (ovf && pend_q) begin
          act_b_q <= !act_b_q;
        end
        // Writing the inactive register arms a swap; active is immediate
        pend_q <= (wr_val[0] && act_b_q) || (wr_val[1] && !act_b_q) ||
                  (pend_q && !ovf);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_irq <= 1'b0;
    end else begin
      cpu_irq <= (|(flag_q & ie_sel & ~dma_req_sel)) ||
                 (ovf_flag_q && ovf_ie_q);
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [CNT_W-1:0] cmp;
    logic [1:0] act;
    logic en, hit, pwm, pol, pin_nx, oc_nx;
    assign map_w[g] = wr_cfg[g] || wr_val[g];
    assign wr_cfg[g] = wr_go && (aw_q == OFF_CFG0 + CH_STRIDE * 8'(g));
    assign wr_val[g] = wr_go && (aw_q == OFF_VAL0 + CH_STRIDE * 8'(g));
    assign map_r[g] = (s_axi_araddr == OFF_CFG0 + CH_STRIDE * 8'(g)) ||
                      (s_axi_araddr == OFF_VAL0 + CH_STRIDE * 8'(g));
    assign act = cfg_q[g][CF_ACT_LSB +: 2];
    assign pwm = cfg_q[g][CF_PWM];
    // Second channel is idle while joined to the first
    assign en = ((act != ACT_NONE) || pwm) && !(g == 1 && buf_on);
    // Buffered pair compares against whichever register is active
    assign cmp = (g == 0 && buf_on && act_b_q) ? val_q[1] : val_q[g];
    // Match is taken on the count about to be entered
    assign hit = en && tick && (cnt_nx == cmp);
    assign pol = (act != ACT_SET);
    assign dma_req_sel[g] = cfg_q[g][CF_DMA] & cfg_q[g][CF_IE];
    assign ie_sel[g] = cfg_q[g][CF_IE];
    always_comb begin
      oc_nx = output_compare[g];
      if (hit) begin
        case (act)
          ACT_TOG: oc_nx = !output_compare[g];
          ACT_CLR: oc_nx = 1'b0;
          ACT_SET: oc_nx = 1'b1;
          default: oc_nx = output_compare[g];
        endcase
      end
      oc_nx = oc_nx ^ (en && ovf && cfg_q[g][CF_TOV]);
      if (!pwm) begin
        pin_nx = oc_nx;
      end else if (cfg_q[g][CF_MAX]) begin
        pin_nx = pol;
      end else if (hit) begin
        pin_nx = !pol;
      end else if (ovf) begin
        pin_nx = pol;
      end else begin
        pin_nx = output_compare[g];
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_q[g] <= CFG_RST;
        val_q[g] <= VAL_RST;
        flag_q[g] <= 1'b0;
        output_compare[g] <= 1'b0;
        output_compare_oe[g] <= 1'b0;
        dma_req[g] <= 1'b0;
      end else begin
        if (wr_cfg[g]) begin
          cfg_q[g] <= (cfg_q[g] & ~wmask[CFG_W-1:0]) | wbits[CFG_W-1:0];
        end
        if (wr_val[g]) begin
          val_q[g] <= (val_q[g] & ~wmask[CNT_W-1:0]) |
                      wbits[CNT_W-1:0];
        end
        // A match in the clearing cycle keeps the flag
        flag_q[g] <= hit ||
                     (flag_q[g] && !(wr_cfg[g] && wbits[CF_FLAG]));
        output_compare[g] <= en ? pin_nx : 1'b0;
        output_compare_oe[g] <= en;
        dma_req[g] <= flag_q[g] && dma_req_sel[g];
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_flag_set;
    g_ch[0].hit |=> flag_q[0];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set after match");

  property p_irq;
    (flag_q[0] && cfg_q[0][CF_IE] && !cfg_q[0][CF_DMA])
      |=> cpu_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("cpu request missing");

  wire pwm0 = cfg_q[0][CF_PWM];
  wire [1:0] act0 = cfg_q[0][CF_ACT_LSB +: 2];
  property p_oc_set;
    (g_ch[0].hit && !pwm0 && act0 == ACT_SET && !cfg_q[0][CF_TOV])
      |=> output_compare[0];
  endproperty
  a_oc_set: assert property (p_oc_set)
    else $error("pin not set on match");

  property p_tov;
    (ovf && !pwm0 && act0 != ACT_NONE && cfg_q[0][CF_TOV] && !g_ch[0].hit &&
     !buf_on) |=> output_compare[0] != $past(output_compare[0]);
  endproperty
  a_tov: assert property (p_tov)
    else $error("pin not toggled on overflow");

  property p_wrap;
    ovf && !crst |=> cnt_q == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap");

  property p_count;
    tick && !wrap && !crst |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_count: assert property (p_count)
    else $error("counter step wrong");

  property p_pwm_start;
    (ovf && pwm0 && !g_ch[0].hit && act0 == ACT_CLR) |=> output_compare[0];
  endproperty
  a_pwm_start: assert property (p_pwm_start)
    else $error("pwm pulse did not start");

  property p_pwm_end;
    (g_ch[0].hit && pwm0 && !cfg_q[0][CF_MAX] && act0 == ACT_CLR)
      |=> !output_compare[0] ##1 !output_compare[0] || $past(ovf);
  endproperty
  a_pwm_end: assert property (p_pwm_end)
    else $error("pwm pulse did not end");

  property p_max;
    (pwm0 && cfg_q[0][CF_MAX] && act0 == ACT_CLR)[*2] |-> output_compare[0];
  endproperty
  a_max: assert property (p_max)
    else $error("full duty not held");

  sequence s_armed;
    buf_on && pend_q && ovf;
  endsequence
  property p_swap;
    s_armed ##1 buf_on |-> act_b_q != $past(act_b_q);
  endproperty
  a_swap: assert property (p_swap)
    else $error("active register did not swap");

  property p_pair_free;
    buf_on [*2] |-> !output_compare_oe[1];
  endproperty
  a_pair_free: assert property (p_pair_free)
    else $error("second pin still driven");

endmodule

// ---- testbench/cpc_load.sv ----
// Passive load on one channel pin that measures high time and period
`timescale 1ns/1ps
module cpc_load (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic [31:0] hi_len_q,
  output logic [31:0] per_len_q
);
  logic prev_q;
  logic [31:0] hcnt_q;
  logic [31:0] pcnt_q;
  wire rise = pin && !prev_q;
  wire fall = !pin && prev_q;

  // A load only senses the pin, so it never draws back on the block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      hcnt_q <= 32'h0000_0000;
      pcnt_q <= 32'h0000_0000;
      hi_len_q <= 32'h0000_0000;
      per_len_q <= 32'h0000_0000;
    end else begin
      prev_q <= pin;
      hcnt_q <= fall ? 32'h0000_0000 : hcnt_q + {31'h0000_0000, pin};
      pcnt_q <= rise ? 32'h0000_0001 : pcnt_q + 32'h0000_0001;
      if (fall) begin
        hi_len_q <= hcnt_q;
      end
      if (rise) begin
        per_len_q <= pcnt_q;
      end
    end
  end
endmodule

// ---- testbench/compare_pwm_channel_pair_test.sv ----
// Self-checking bench for the compare and PWM channel pair
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("wrong value %s exp %0h got %0h", nm, e, g); \
    end \
  end
module compare_pwm_channel_pair_test;
  import cpc_pkg::*;
  localparam int LIMIT = 20000;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] K_FLAG = ONE << CF_FLAG;
  localparam logic [31:0] K_IE = ONE << CF_IE;
  localparam logic [31:0] K_DMA = ONE << CF_DMA;
  localparam logic [31:0] K_PWM = ONE << CF_PWM;
  localparam logic [31:0] K_BUF = ONE << CF_BUF;
  localparam logic [31:0] K_TOV = ONE << CF_TOV;
  localparam logic [31:0] K_MAX = ONE << CF_MAX;
  localparam logic [31:0] K_ACTB = ONE << CF_ACTB;
  localparam logic [31:0] K_GO = ONE | (ONE << CTRL_CRST);
  logic aclk;
  logic aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, hi_len, per_len, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, cpu_irq;
  logic [NCH-1:0] output_compare, output_compare_oe, dma_req;
  logic [15:0] m, v, b;
  logic [1:0] act;
  logic o;
  int fails, n_checks, cyc, ps;

  cpc_top i_cpc_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .output_compare(output_compare),
    .output_compare_oe(output_compare_oe), .cpu_irq(cpu_irq),
    .dma_req(dma_req));
  cpc_load i_cpc_load (.aclk(aclk), .aresetn(aresetn),
    .pin(output_compare[0]), .hi_len_q(hi_len), .per_len_q(per_len));

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  task automatic wrap_up;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      $display("wrong value run length exp done got hang");
      wrap_up();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] dw,
                    input logic [1:0] er);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dw;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && s_axi_awready === 1'b1) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready === 1'b1) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    `CHK("bresp", er, s_axi_bresp)
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dr,
                    output logic [1:0] rr);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    dr = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] mk, e);
    rd(a, d, r);
    `CHK("register", e, d & mk)
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Clear the overflow flag and poll it, as an overflow handler would
  task automatic at_ovf;
    wr(OFF_STAT, ONE << ST_OVF, RESP_OKAY);
    d = 32'h0000_0000;
    while (d[ST_OVF] !== 1'b1) begin
      rd(OFF_STAT, d, r);
    end
  endtask

  // Expected high time of a PWM wave in clock cycles
  function automatic logic [31:0] pwm_hi(input logic [1:0] a,
      input logic [15:0] val, mv, input int p);
    if (a == ACT_SET) begin
      return ({16'h0000, mv} + ONE - {16'h0000, val}) << p;
    end
    return {16'h0000, val} << p;
  endfunction

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    void'($urandom(32'hed4a));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(OFF_MOD, 32'hffff_ffff, 32'h0000_ffff);
    rdc(OFF_CFG0, 32'hffff_ffff, 32'h0000_0000);
    rd(8'h40, d, r);
    `CHK("rresp", RESP_SLVERR, r)
    wr(8'h40, ONE, RESP_SLVERR);
    // Compare mode: toggle on match, interrupt then DMA routing
    m = 16'd20 + 16'($urandom_range(20));
    v = 16'd1 + 16'($urandom_range(18));
    wr(OFF_MOD, {16'h0000, m}, RESP_OKAY);
    wr(OFF_VAL0, {16'h0000, v}, RESP_OKAY);
    wr(OFF_CFG0, K_IE | (32'(ACT_TOG) << CF_ACT_LSB), RESP_OKAY);
    wr(OFF_CTRL, K_GO, RESP_OKAY);
    waitc(4 * (int'(m) + 1));
    `CHK("toggle high", {16'h0000, m} + ONE, hi_len)
    `CHK("cpu_irq", 1'b1, cpu_irq)
    rdc(OFF_CFG0, K_FLAG, K_FLAG);
    wr(OFF_CFG0, K_FLAG | K_IE | K_DMA | (32'(ACT_TOG) << CF_ACT_LSB),
       RESP_OKAY);
    waitc(int'(m) + 4);
    `CHK("dma_req", 1'b1, dma_req[0])
    `CHK("cpu_irq off", 1'b0, cpu_irq)
    // Drive high, then low, on match
    for (int i = 0; i < 2; i++) begin
      act = (i == 0) ? ACT_SET : ACT_CLR;
      wr(OFF_CFG0, 32'(act) << CF_ACT_LSB, RESP_OKAY);
      waitc(int'(m) + 3);
      `CHK("pin level", (i == 0), output_compare[0])
      `CHK("cpu_irq masked", 1'b0, cpu_irq)
    end
    // Set on match with toggle on overflow, new value each pass
    for (int i = 0; i < 2; i++) begin
      v = 16'd1 + 16'($urandom_range(int'(m) - 2));
      at_ovf();
      wr(OFF_VAL0, {16'h0000, v}, RESP_OKAY);
      wr(OFF_CFG0, K_TOV | (32'(ACT_SET) << CF_ACT_LSB), RESP_OKAY);
      waitc(3 * (int'(m) + 1));
      `CHK("tov high", pwm_hi(ACT_SET, v, m, 0), hi_len)
    end
    // PWM period and duty over prescaler rates and both polarities
    for (int i = 0; i < 3; i++) begin
      ps = i;
      m = (i == 0) ? 16'h00ff : 16'd10 + 16'($urandom_range(50));
      v = (i == 0) ? 16'h0080 : 16'd1 + 16'($urandom_range(int'(m) - 1));
      act = (i == 2) ? ACT_SET : ACT_CLR;
      at_ovf();
      wr(OFF_MOD, {16'h0000, m}, RESP_OKAY);
      wr(OFF_VAL0, {16'h0000, v}, RESP_OKAY);
      wr(OFF_CFG0, K_PWM | (32'(act) << CF_ACT_LSB), RESP_OKAY);
      wr(OFF_CTRL, K_GO | (32'(ps) << CTRL_PS_LSB), RESP_OKAY);
      waitc(((3 * (int'(m) + 1)) << ps) + 4);
      `CHK("pwm high", pwm_hi(act, v, m, ps), hi_len)
      `CHK("pwm period", ({16'h0000, m} + ONE) << ps, per_len)
      `CHK("tick scale", ({16'h0000, m} + ONE) << ps, per_len)
    end
    // Zero duty, then forced full duty
    for (int i = 0; i < 2; i++) begin
      wr(OFF_VAL0, 32'h0000_0000, RESP_OKAY);
      wr(OFF_CFG0, K_PWM | (i == 1 ? K_MAX : 32'h0000_0000) |
         (32'(ACT_CLR) << CF_ACT_LSB), RESP_OKAY);
      // The old polarity holds until the next match, one period away
      waitc((int'(m) + 1) << ps);
      repeat (6) begin
        waitc(7 + int'($urandom_range(40)));
        `CHK("fixed duty", (i == 1), output_compare[0])
      end
    end
    // Buffered PWM pair: swap at overflow after a write
    m = 16'd20 + 16'($urandom_range(30));
    v = 16'd1 + 16'($urandom_range(int'(m) - 1));
    b = 16'd1 + 16'($urandom_range(int'(m) - 1));
    wr(OFF_MOD, {16'h0000, m}, RESP_OKAY);
    wr(OFF_VAL0, {16'h0000, v}, RESP_OKAY);
    wr(OFF_CFG0, K_BUF | K_PWM | (32'(ACT_CLR) << CF_ACT_LSB), RESP_OKAY);
    wr(OFF_CFG0 + CH_STRIDE, 32'(ACT_TOG) << CF_ACT_LSB, RESP_OKAY);
    wr(OFF_CTRL, K_GO, RESP_OKAY);
    waitc(3 * (int'(m) + 1));
    `CHK("buf A", pwm_hi(ACT_CLR, v, m, 0), hi_len)
    wr(OFF_VAL0 + CH_STRIDE, {16'h0000, b}, RESP_OKAY);
    waitc(3 * (int'(m) + 1));
    `CHK("buf B", pwm_hi(ACT_CLR, b, m, 0), hi_len)
    rdc(OFF_CFG0, K_ACTB, K_ACTB);
    `CHK("pin B oe", 1'b0, output_compare_oe[1])
    v = 16'd1 + 16'($urandom_range(int'(m) - 1));
    wr(OFF_VAL0, {16'h0000, v}, RESP_OKAY);
    waitc(3 * (int'(m) + 1));
    `CHK("buf A again", pwm_hi(ACT_CLR, v, m, 0), hi_len)
    rdc(OFF_CFG0, K_ACTB, 32'h0000_0000);
    // Leaving the pair hands the second pin back to its own channel
    wr(OFF_CFG0, K_PWM | (32'(ACT_CLR) << CF_ACT_LSB), RESP_OKAY);
    o = output_compare[1];
    waitc(int'(m) + 1);
    `CHK("pin A oe", 1'b1, output_compare_oe[0])
    `CHK("pin B oe on", 1'b1, output_compare_oe[1])
    `CHK("pin B toggle", !o, output_compare[1])
    wrap_up();
  end
endmodule
